// File: rtl/cts_pkg.sv
package cts_pkg;

    // Register offsets on the byte-wide register port
    localparam logic [7:0] CTS_OFS_SCAN_GO = 8'hCA;
    localparam logic [7:0] CTS_OFS_CHG_DIV = 8'hCB;
    localparam logic [7:0] CTS_OFS_CFG_B = 8'hCC;
    localparam logic [7:0] CTS_OFS_CFG_C = 8'hCD;
    localparam logic [7:0] CTS_OFS_RAW_LO = 8'hCE;
    localparam logic [7:0] CTS_OFS_RAW_HI = 8'hCF;
    localparam logic [7:0] CTS_OFS_PULL_LO = 8'hD1;
    localparam logic [7:0] CTS_OFS_ANA = 8'hD2;
    localparam logic [7:0] CTS_OFS_PIN_A = 8'hD3;
    localparam logic [7:0] CTS_OFS_PIN_B = 8'hD4;
    localparam logic [7:0] CTS_OFS_PIN_C = 8'hD5;
    localparam logic [7:0] CTS_OFS_PIN_D = 8'hD6;

    // Reset values
    localparam logic [7:0] CTS_RST_ZERO = 8'h00;
    localparam logic [7:0] CTS_RST_CFG_B = 8'h40;
    localparam logic [7:0] CTS_RST_CFG_C = 8'h70;
    localparam logic [7:0] CTS_RST_ANA = 8'h2F;

    // Field positions
    localparam int CTS_GO_BIT = 0;
    localparam int CTS_DIV_MSB = 5;
    localparam int CTS_MSB_BIT = 6;
    localparam int CTS_PAR_BIT = 5;
    localparam int CTS_IDX_MSB = 4;
    localparam int CTS_WID_LSB = 4;
    localparam int CTS_CLK_LSB = 2;
    localparam int CTS_RB_LSB = 3;
    localparam int CTS_VTH_LSB = 0;
    localparam int CTS_PIN_D_MSB = 1;

    // Channel and mode codes
    localparam int CTS_NUM_CH = 26;
    localparam logic [4:0] CTS_LAST_CH = 5'h19;
    localparam logic [2:0] CTS_RB_60K = 3'h4;
    localparam logic [2:0] CTS_RB_80K = 3'h5;
    localparam logic [5:0] CTS_DIV_NORMAL = 6'h3E;
    localparam logic [5:0] CTS_DIV_UNIFORM = 6'h3F;

    // Rates in MHz; the source clock is halved before the divider
    localparam int CTS_REF_MHZ = 10;
    localparam int CTS_SRC_MHZ = 48;
    localparam logic [5:0] CTS_HALF_SRC = 6'(CTS_SRC_MHZ / 2);
    localparam int CTS_DIV_OFFSET = 4;
    localparam int CTS_SPREAD_MIN = 8;
    localparam int CTS_MIN_WIDTH = 9;

    typedef enum logic [0:0] {
        CTS_IDLE = 1'b0,
        CTS_SCAN = 1'b1
    } cts_state_e;

    // Count clock rate in MHz for each select code
    function automatic logic [5:0] cts_count_rate(input logic [1:0] sel);
        case (sel)
            2'h0: cts_count_rate = 6'h18;
            2'h1: cts_count_rate = 6'h0C;
            2'h2: cts_count_rate = 6'h06;
            default: cts_count_rate = 6'h04;
        endcase
    endfunction

    // Full-scale count for a counter width code
    function automatic logic [15:0] cts_full_scale(input logic [2:0] sel);
        logic [16:0] one;
        one = 17'h00001 << (CTS_MIN_WIDTH + int'(sel));
        cts_full_scale = 16'(one - 17'h00001);
    endfunction

endpackage

// File: rtl/cts_scan_counter.sv
`timescale 1ns/10ps
module cts_scan_counter
    import cts_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic clr,
    input wire logic [1:0] ticks,
    input wire logic hit,
    input wire logic [2:0] width_sel,
    output logic [15:0] count,
    output logic done
);

    logic [16:0] window;
    logic [16:0] win_cnt;
    logic [16:0] next_win;
    logic [16:0] next_sum;
    logic [15:0] full;

    // Window spans 2^width count ticks
    always_comb begin
        full = cts_full_scale(width_sel);
        window = {1'b0, full} + 17'h00001;
        next_win = win_cnt + {15'h0000, ticks};
        next_sum = {1'b0, count} + {15'h0000, ticks};
    end

    assign done = (win_cnt >= window);

    // Window progress, frozen once complete
    always_ff @(posedge clk) begin
        if (!rst_n || (ce && clr)) begin
            win_cnt <= 17'h00000;
        end else if (ce && !done) begin
            win_cnt <= next_win;
        end
    end

    // Hit count clamps at full scale instead of wrapping
    always_ff @(posedge clk) begin
        if (!rst_n || (ce && clr)) begin
            count <= 16'h0000;
        end else if (ce && !done && hit) begin
            if (next_sum > {1'b0, full}) begin
                count <= full;
            end else begin
                count <= next_sum[15:0];
            end
        end
    end

endmodule

// File: rtl/cts_touch_scan.sv
// Local design decision: the plain strobed port.
`timescale 1ns/10ps
module cts_touch_scan
    import cts_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic RSTN,
    input wire logic CE,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    input wire logic SENSE_CMP,
    output logic [25:0] SENSE_EN,
    output logic [4:0] CHANNEL_INDEX,
    output logic PARALLEL_MODE,
    output logic [8:0] PULLUP_CODE,
    output logic [2:0] BIAS_RES_CODE,
    output logic BIAS_RES_VALID,
    output logic [2:0] VTH_CODE,
    output logic CHARGE_CLK,
    output logic SCAN_ACTIVE,
    output logic SCAN_DONE
);

    // Software-visible registers
    logic scan_go;
    logic [5:0] chg_div;
    logic pullup_msb;
    logic parallel;
    logic [4:0] chan_idx;
    logic [2:0] width_sel;
    logic [1:0] clk_sel;
    logic [7:0] pullup_low;
    logic [2:0] bias_sel;
    logic [2:0] threshold_voltage_sel;
    logic [7:0] pin_a;
    logic [7:0] pin_b;
    logic [7:0] pin_c;
    logic [1:0] pin_d;
    logic [7:0] raw_lo;
    logic [7:0] raw_hi;

    // Scan engine state
    cts_state_e state;
    cts_state_e next_state;
    logic cmp_meta;
    logic cmp_sync;
    logic [4:0] tick_acc;
    logic [5:0] tick_sum;
    logic [1:0] ticks;
    logic [4:0] next_acc;
    logic [8:0] chg_acc;
    logic [8:0] chg_sum;
    logic [8:0] half_period;
    logic [4:0] chg_divisor;
    logic [7:0] lfsr;
    logic [15:0] scan_count;
    logic window_done;
    logic scan_end;
    logic go_wr;
    logic [7:0] rd_mux;
    logic [25:0] next_en;

    assign go_wr = WR && (ADDR == CTS_OFS_SCAN_GO);
    assign scan_end = (state == CTS_SCAN) && window_done;

    // Two-stage synchroniser for the analog comparator
    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            cmp_meta <= 1'b0;
            cmp_sync <= 1'b0;
        end else if (CE) begin
            cmp_meta <= SENSE_CMP;
            cmp_sync <= cmp_meta;
        end
    end

    // Configuration registers written from the register port
    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            chg_div <= CTS_RST_ZERO[5:0];
            pullup_msb <= CTS_RST_CFG_B[CTS_MSB_BIT];
            parallel <= CTS_RST_CFG_B[CTS_PAR_BIT];
            chan_idx <= CTS_RST_CFG_B[CTS_IDX_MSB:0];
            width_sel <= CTS_RST_CFG_C[CTS_WID_LSB +: 3];
            clk_sel <= CTS_RST_CFG_C[CTS_CLK_LSB +: 2];
            pullup_low <= CTS_RST_ZERO;
            bias_sel <= CTS_RST_ANA[CTS_RB_LSB +: 3];
            threshold_voltage_sel <= CTS_RST_ANA[CTS_VTH_LSB +: 3];
            pin_a <= CTS_RST_ZERO;
            pin_b <= CTS_RST_ZERO;
            pin_c <= CTS_RST_ZERO;
            pin_d <= CTS_RST_ZERO[CTS_PIN_D_MSB:0];
        end else if (CE && WR) begin
            case (ADDR)
                CTS_OFS_CHG_DIV: begin
                    chg_div <= WDATA[CTS_DIV_MSB:0];
                end
                CTS_OFS_CFG_B: begin
                    pullup_msb <= WDATA[CTS_MSB_BIT];
                    parallel <= WDATA[CTS_PAR_BIT];
                    chan_idx <= WDATA[CTS_IDX_MSB:0];
                end
                CTS_OFS_CFG_C: begin
                    width_sel <= WDATA[CTS_WID_LSB +: 3];
                    clk_sel <= WDATA[CTS_CLK_LSB +: 2];
                end
                CTS_OFS_PULL_LO: begin
                    pullup_low <= WDATA;
                end
                CTS_OFS_ANA: begin
                    bias_sel <= WDATA[CTS_RB_LSB +: 3];
                    threshold_voltage_sel <= WDATA[CTS_VTH_LSB +: 3];
                end
                CTS_OFS_PIN_A: begin
                    pin_a <= WDATA;
                end
                CTS_OFS_PIN_B: begin
                    pin_b <= WDATA;
                end
                CTS_OFS_PIN_C: begin
                    pin_c <= WDATA;
                end
                CTS_OFS_PIN_D: begin
                    pin_d <= WDATA[CTS_PIN_D_MSB:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Go bit: software write wins over the end-of-scan clear
    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            scan_go <= CTS_RST_ZERO[CTS_GO_BIT];
        end else if (CE) begin
            if (go_wr) begin
                scan_go <= WDATA[CTS_GO_BIT];
            end else if (scan_end) begin
                scan_go <= 1'b0;
            end
        end
    end

    // Scan sequencing; a cleared go bit aborts at once
    always_comb begin
        next_state = state;
        case (state)
            CTS_IDLE: begin
                if (scan_go) begin
                    next_state = CTS_SCAN;
                end
            end
            CTS_SCAN: begin
                if (!scan_go || window_done) begin
                    next_state = CTS_IDLE;
                end
            end
            default: begin
                next_state = CTS_IDLE;
            end
        endcase
    end

    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            state <= CTS_IDLE;
        end else if (CE) begin
            state <= next_state;
        end
    end

    // Count ticks per reference cycle; 24 MHz yields up to three
    always_comb begin
        tick_sum = {1'b0, tick_acc} + cts_count_rate(clk_sel);
        if (tick_sum >= 6'(3 * CTS_REF_MHZ)) begin
            ticks = 2'h3;
        end else if (tick_sum >= 6'(2 * CTS_REF_MHZ)) begin
            ticks = 2'h2;
        end else if (tick_sum >= 6'(CTS_REF_MHZ)) begin
            ticks = 2'h1;
        end else begin
            ticks = 2'h0;
        end
        next_acc = 5'(tick_sum - 6'(int'(ticks) * CTS_REF_MHZ));
    end

    // Fractional rate accumulator, cleared outside a scan
    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            tick_acc <= 5'h00;
        end else if (CE) begin
            if (state == CTS_SCAN) begin
                tick_acc <= next_acc;
            end else begin
                tick_acc <= 5'h00;
            end
        end
    end

    // Counter and window, held clear while idle or aborted
    cts_scan_counter u_counter (
        .clk(REF_CLK),
        .rst_n(RSTN),
        .ce(CE),
        .clr(state != CTS_SCAN),
        .ticks(ticks),
        .hit(cmp_sync),
        .width_sel(width_sel),
        .count(scan_count),
        .done(window_done)
    );

    // Both raw bytes captured in one edge at scan end
    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            raw_lo <= CTS_RST_ZERO;
            raw_hi <= CTS_RST_ZERO;
        end else if (CE && scan_end) begin
            raw_lo <= scan_count[7:0];
            raw_hi <= scan_count[15:8];
        end
    end

    // Charge divisor: fixed codes, or a random pick for spread modes
    always_comb begin
        if (chg_div == CTS_DIV_UNIFORM) begin
            chg_divisor = 5'(CTS_SPREAD_MIN) + {1'b0, lfsr[3:0]};
        end else if (chg_div == CTS_DIV_NORMAL) begin
            chg_divisor = 5'(CTS_SPREAD_MIN) + {2'h0, lfsr[2:0]}
                + {2'h0, lfsr[6:4]};
        end else begin
            chg_divisor = 5'h00;
        end
    end

    // Half period in units of source/2 MHz per reference cycle
    always_comb begin
        if (chg_div >= CTS_DIV_NORMAL) begin
            half_period = 9'(int'(chg_divisor) * CTS_REF_MHZ / 2);
        end else begin
            half_period = 9'((int'(chg_div) + CTS_DIV_OFFSET)
                * CTS_REF_MHZ / 2);
        end
        chg_sum = chg_acc + {3'h0, CTS_HALF_SRC};
    end

    // Charge clock toggles only while scanning, parked low otherwise
    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            chg_acc <= 9'h000;
            CHARGE_CLK <= 1'b0;
        end else if (CE) begin
            if (state != CTS_SCAN) begin
                chg_acc <= 9'h000;
                CHARGE_CLK <= 1'b0;
            end else if (chg_sum >= half_period) begin
                chg_acc <= chg_sum - half_period;
                CHARGE_CLK <= !CHARGE_CLK;
            end else begin
                chg_acc <= chg_sum;
            end
        end
    end

    // Spread pattern source, stepped once per charge clock edge
    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            lfsr <= 8'h01;
        end else if (CE && state == CTS_SCAN && chg_sum >= half_period) begin
            lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
        end
    end

    // Electrode enables: parallel set or one decoded channel
    always_comb begin
        next_en = '0;
        if (parallel) begin
            next_en = {pin_d, pin_c, pin_b, pin_a};
        end else if (chan_idx <= CTS_LAST_CH) begin
            next_en[chan_idx] = 1'b1;
        end
    end

    // Analog front-end controls, registered for clean pins
    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            SENSE_EN <= '0;
            CHANNEL_INDEX <= CTS_RST_CFG_B[CTS_IDX_MSB:0];
            PARALLEL_MODE <= CTS_RST_CFG_B[CTS_PAR_BIT];
            PULLUP_CODE <= {CTS_RST_CFG_B[CTS_MSB_BIT], CTS_RST_ZERO};
            BIAS_RES_CODE <= CTS_RST_ANA[CTS_RB_LSB +: 3];
            BIAS_RES_VALID <= 1'b0;
            VTH_CODE <= CTS_RST_ANA[CTS_VTH_LSB +: 3];
        end else if (CE) begin
            SENSE_EN <= next_en;
            CHANNEL_INDEX <= chan_idx;
            PARALLEL_MODE <= parallel;
            PULLUP_CODE <= {pullup_msb, pullup_low};
            BIAS_RES_CODE <= bias_sel;
            // Reserved bias codes flagged so the front end ignores them
            BIAS_RES_VALID <= (bias_sel == CTS_RB_60K)
                || (bias_sel == CTS_RB_80K);
            VTH_CODE <= threshold_voltage_sel;
        end
    end

    // Scan status: level while busy, one-cycle pulse at the end
    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            SCAN_ACTIVE <= 1'b0;
            SCAN_DONE <= 1'b0;
        end else if (CE) begin
            SCAN_ACTIVE <= (next_state == CTS_SCAN);
            SCAN_DONE <= scan_end;
        end
    end

    // Read decode; reserved bits and unmapped offsets read zero
    always_comb begin
        rd_mux = 8'h00;
        case (ADDR)
            CTS_OFS_SCAN_GO: rd_mux[CTS_GO_BIT] = scan_go;
            CTS_OFS_CHG_DIV: rd_mux[CTS_DIV_MSB:0] = chg_div;
            CTS_OFS_CFG_B: begin
                rd_mux[CTS_MSB_BIT] = pullup_msb;
                rd_mux[CTS_PAR_BIT] = parallel;
                rd_mux[CTS_IDX_MSB:0] = chan_idx;
            end
            CTS_OFS_CFG_C: begin
                rd_mux[CTS_WID_LSB +: 3] = width_sel;
                rd_mux[CTS_CLK_LSB +: 2] = clk_sel;
            end
            CTS_OFS_RAW_LO: rd_mux = raw_lo;
            CTS_OFS_RAW_HI: rd_mux = raw_hi;
            CTS_OFS_PULL_LO: rd_mux = pullup_low;
            CTS_OFS_ANA: begin
                rd_mux[CTS_RB_LSB +: 3] = bias_sel;
                rd_mux[CTS_VTH_LSB +: 3] = threshold_voltage_sel;
            end
            CTS_OFS_PIN_A: rd_mux = pin_a;
            CTS_OFS_PIN_B: rd_mux = pin_b;
            CTS_OFS_PIN_C: rd_mux = pin_c;
            CTS_OFS_PIN_D: rd_mux[CTS_PIN_D_MSB:0] = pin_d;
            default: rd_mux = 8'h00;
        endcase
    end

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            RDATA <= 8'h00;
        end else if (CE) begin
            RDATA <= RD ? rd_mux : 8'h00;
        end
    end

endmodule

// File: verification/cts_electrode_model.sv
`timescale 1ns/10ps
// Electrodes plus comparator: a touched pad only hits when a pin is enabled
module cts_electrode_model (
    input wire logic clk,
    input wire logic [25:0] sense_en,
    input wire logic touch,
    output logic cmp
);
    // Registered on the same clock, so the hit reaches the block one cycle after the enables
    always_ff @(posedge clk) begin
        cmp <= touch && (|sense_en);
    end
endmodule

// File: verification/cts_touch_scan_monitor.sv
`timescale 1ns/10ps
module cts_touch_scan_monitor
    import cts_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic RSTN,
    input wire logic CE,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [7:0] RDATA,
    input wire logic [25:0] SENSE_EN,
    input wire logic [4:0] CHANNEL_INDEX,
    input wire logic PARALLEL_MODE,
    input wire logic [8:0] PULLUP_CODE,
    input wire logic [2:0] BIAS_RES_CODE,
    input wire logic BIAS_RES_VALID,
    input wire logic [2:0] VTH_CODE,
    input wire logic CHARGE_CLK,
    input wire logic SCAN_ACTIVE,
    input wire logic SCAN_DONE
);
    logic [7:0] last_pull;
    logic [2:0] last_vth;
    logic [25:0] sel_mask;
    // Last bytes written, so outputs are tied to software writes
    always_ff @(posedge REF_CLK) begin
        if (CE && WR && ADDR == CTS_OFS_PULL_LO) begin
            last_pull <= WDATA;
        end
    end
    always_ff @(posedge REF_CLK) begin
        if (CE && WR && ADDR == CTS_OFS_ANA) begin
            last_vth <= WDATA[2:0];
        end
    end
    // Reserved index codes select no pin at all
    assign sel_mask = (CHANNEL_INDEX <= CTS_LAST_CH) ?
        (26'h1 << CHANNEL_INDEX) : 26'h0;
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!RSTN);
    sequence s_go_write;
        CE && WR && ADDR == CTS_OFS_SCAN_GO && WDATA[0] && !SCAN_ACTIVE;
    endsequence
    sequence s_stop_write;
        CE && WR && ADDR == CTS_OFS_SCAN_GO && !WDATA[0] && SCAN_ACTIVE;
    endsequence
    sequence s_scan_runs;
        ##2 SCAN_ACTIVE;
    endsequence
    a_go_starts: assert property (s_go_write |-> s_scan_runs)
        else $error("scan did not start after go");
    a_abort_stops: assert property (s_stop_write |-> ##2
        (!SCAN_ACTIVE && !SCAN_DONE)) else $error("abort did not stop");
    a_done_pulse: assert property (SCAN_DONE |=> !SCAN_DONE)
        else $error("done longer than one cycle");
    a_done_after_scan: assert property ($rose(SCAN_DONE) |->
        $past(SCAN_ACTIVE) && !SCAN_ACTIVE) else $error("done out of scan");
    a_charge_quiet: assert property (!SCAN_ACTIVE &&
        !$past(SCAN_ACTIVE) && !$past(SCAN_ACTIVE, 2) |-> !CHARGE_CLK)
        else $error("charge clock runs outside scan");
    a_rdata_idle: assert property (CE && $past(CE) && !$past(RD) |->
        RDATA == 8'h00) else $error("read data outside read cycle");
    a_pull_follow: assert property (CE && WR &&
        ADDR == CTS_OFS_PULL_LO |-> ##2 PULLUP_CODE[7:0] == last_pull)
        else $error("pull-up code not updated");
    a_vth_follow: assert property (CE && WR &&
        ADDR == CTS_OFS_ANA |-> ##2 VTH_CODE == last_vth)
        else $error("threshold code not updated");
    a_bias_valid: assert property ($past(RSTN) &&
        $stable(BIAS_RES_CODE) |-> BIAS_RES_VALID ==
        (BIAS_RES_CODE == CTS_RB_60K || BIAS_RES_CODE == CTS_RB_80K))
        else $error("bias valid wrong");
    a_single_pin: assert property (!PARALLEL_MODE &&
        $stable(PARALLEL_MODE) && $stable(CHANNEL_INDEX) && SCAN_ACTIVE
        |-> (SENSE_EN & ~sel_mask) == 26'h0)
        else $error("unselected pin enabled");
endmodule
bind cts_touch_scan cts_touch_scan_monitor u_mon (.REF_CLK(REF_CLK),
    .RSTN(RSTN), .CE(CE), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .SENSE_EN(SENSE_EN), .CHANNEL_INDEX(CHANNEL_INDEX),
    .PARALLEL_MODE(PARALLEL_MODE), .PULLUP_CODE(PULLUP_CODE),
    .BIAS_RES_CODE(BIAS_RES_CODE), .BIAS_RES_VALID(BIAS_RES_VALID),
    .VTH_CODE(VTH_CODE), .CHARGE_CLK(CHARGE_CLK),
    .SCAN_ACTIVE(SCAN_ACTIVE), .SCAN_DONE(SCAN_DONE));

// File: verification/tb_cap_touch_scan_config.sv
`timescale 1ns/10ps
module tb_cap_touch_scan_config
    import cts_pkg::*;
;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic ce = 1'b1;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic touch = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    logic sense_cmp;
    logic [25:0] sense_en;
    logic [4:0] chan_idx;
    logic par_mode, bias_valid, charge_clk, scan_active, scan_done;
    logic [8:0] pullup_code;
    logic [2:0] bias_code, vth_code;
    int n_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [7:0] offs [13] = '{8'hCA, 8'hCB, 8'hCC, 8'hCD, 8'hCE, 8'hCF,
        8'hD0, 8'hD1, 8'hD2, 8'hD3, 8'hD4, 8'hD5, 8'hD6};
    logic [7:0] rstv [13] = '{8'h00, 8'h00, 8'h40, 8'h70, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h2F, 8'h00, 8'h00, 8'h00, 8'h00};
    // Reserved bits read zero after writing all ones
    logic [7:0] maskv [13] = '{8'h00, 8'h3F, 8'h7F, 8'h7C, 8'h00, 8'h00,
        8'h00, 8'hFF, 8'h3F, 8'hFF, 8'hFF, 8'hFF, 8'h03};
    int rate [4] = '{24, 12, 6, 4};

    cts_touch_scan u_dut (.REF_CLK(ref_clk), .RSTN(rstn), .CE(ce),
        .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .SENSE_CMP(sense_cmp), .SENSE_EN(sense_en),
        .CHANNEL_INDEX(chan_idx), .PARALLEL_MODE(par_mode),
        .PULLUP_CODE(pullup_code), .BIAS_RES_CODE(bias_code),
        .BIAS_RES_VALID(bias_valid), .VTH_CODE(vth_code),
        .CHARGE_CLK(charge_clk), .SCAN_ACTIVE(scan_active),
        .SCAN_DONE(scan_done));
    cts_electrode_model u_model (.clk(ref_clk), .sense_en(sense_en),
        .touch(touch), .cmp(sense_cmp));

    initial begin
        forever #50 ref_clk = ~ref_clk;
    end

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Longest scan is about 27k cycles; anything past this is a hang
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 60000) begin
            n_errors++;
            end_sim();
        end
    end

    task automatic chk(input string name, input logic [25:0] exp,
        input logic [25:0] got);
        comparisons++;
        if (got !== exp) begin
            $display("unexpected %s expected %h seen %h", name, exp, got);
            n_errors++;
        end
    endtask
    // Cycle counts carry accumulator jitter, so a tolerance applies
    task automatic near(input string name, input int exp, input int got,
        input int tol);
        comparisons++;
        if (got < exp - tol || got > exp + tol) begin
            $display("unexpected %s expected %0d seen %0d", name, exp, got);
            n_errors++;
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        rd_reg(a, d);
        chk("rdata", 26'(e), 26'(d));
    endtask
    task automatic raw_chk(input logic [15:0] e);
        logic [7:0] lo, hi;
        rd_reg(CTS_OFS_RAW_LO, lo);
        rd_reg(CTS_OFS_RAW_HI, hi);
        chk("raw count", 26'(e), 26'({hi, lo}));
    endtask
    // Start one scan and measure its length and charge clock rising edges
    task automatic run_scan(input logic [7:0] cfg, output int len,
        output int rises);
        logic prev;
        int i;
        wr_reg(CTS_OFS_CFG_C, cfg);
        wr_reg(CTS_OFS_SCAN_GO, 8'h01);
        len = 0;
        rises = 0;
        prev = 1'b0;
        for (i = 0; i < 30000 && scan_done !== 1'b1; i++) begin
            @(posedge ref_clk);
            #1;
            if (scan_active === 1'b1) len++;
            if (charge_clk === 1'b1 && prev === 1'b0) rises++;
            prev = charge_clk;
        end
    endtask
    task automatic start_abort(input logic [7:0] cfg_b,
        input logic [25:0] exp);
        wr_reg(CTS_OFS_CFG_B, cfg_b);
        wr_reg(CTS_OFS_SCAN_GO, 8'h01);
        repeat (2) @(posedge ref_clk);
        #1 chk("sense enables", exp, sense_en);
        chk("channel index", 26'(cfg_b[4:0]), 26'(chan_idx));
        chk("parallel mode", 26'(cfg_b[5]), 26'(par_mode));
        wr_reg(CTS_OFS_SCAN_GO, 8'h00);
        repeat (3) @(posedge ref_clk);
    endtask

    initial begin
        int k, len, rises, w;
        repeat (12) @(posedge ref_clk);
        rstn <= 1'b1;
        for (k = 0; k < 13; k++) rd_chk(offs[k], rstv[k]);
        chk("pullup code", 26'h100, 26'(pullup_code));
        $display("test reset values done");
        for (k = 1; k < 13; k++) wr_reg(offs[k], 8'hFF);
        for (k = 1; k < 13; k++) rd_chk(offs[k], maskv[k]);
        chk("pullup code", 26'h1FF, 26'(pullup_code));
        wr_reg(CTS_OFS_CFG_B, 8'h03);
        repeat (3) @(posedge ref_clk);
        chk("pullup code", 26'h0FF, 26'(pullup_code));
        // A write while the clock enable is low must be dropped
        ce <= 1'b0;
        wr_reg(CTS_OFS_PULL_LO, 8'h5A);
        ce <= 1'b1;
        rd_chk(CTS_OFS_PULL_LO, 8'hFF);
        for (k = 0; k < 8; k++) begin
            wr_reg(CTS_OFS_ANA, {2'b00, 3'(k), 3'(k)});
            repeat (3) @(posedge ref_clk);
            chk("bias valid", 26'(k == 4 || k == 5), 26'(bias_valid));
            chk("threshold code", 26'(k), 26'(vth_code));
            chk("bias code", 26'(k), 26'(bias_code));
        end
        $display("test register access done");
        // Scans on pin 3 held touched: every tick counts, then saturates
        for (k = 9; k < 13; k++) wr_reg(offs[k], 8'h00);
        wr_reg(CTS_OFS_ANA, 8'h2F);
        wr_reg(CTS_OFS_CHG_DIV, 8'h14);
        touch <= 1'b1;
        for (k = 0; k < 4; k++) begin
            run_scan({4'h0, 2'(k), 2'b00}, len, rises);
            near("scan cycles", 5120 / rate[k], len, 4);
            near("charge edges", len / 10, rises, 3);
            raw_chk(16'h01FF);
        end
        // Spread codes keep the charge clock between 1 and 3 MHz
        for (k = 0; k < 2; k++) begin
            wr_reg(CTS_OFS_CHG_DIV, {2'b00, CTS_DIV_NORMAL} + 8'(k));
            run_scan(8'h00, len, rises);
            near("spread edges", len / 5, rises, len / 10 + 2);
        end
        for (k = 0; k < 2; k++) begin
            w = (k == 0) ? 1 : 7;
            run_scan({1'b0, 3'(w), 4'h0}, len, rises);
            near("scan cycles", (512 << w) * 10 / 24, len, 6);
            raw_chk(16'((32'h1 << (9 + w)) - 1));
        end
        $display("test scan timing done");
        for (k = 0; k < 27; k++) begin
            start_abort(8'(k), (k < 26) ? (26'h1 << k) : 26'h0);
        end
        chk("scan active", 26'h0, 26'(scan_active));
        raw_chk(16'hFFFF);
        wr_reg(CTS_OFS_PIN_A, 8'h81);
        wr_reg(CTS_OFS_PIN_B, 8'h42);
        wr_reg(CTS_OFS_PIN_C, 8'h24);
        wr_reg(CTS_OFS_PIN_D, 8'h03);
        start_abort(8'h60, 26'h3244281);
        $display("test channel select done");
        touch <= 1'b0;
        wr_reg(CTS_OFS_CFG_B, 8'h03);
        run_scan(8'h00, len, rises);
        raw_chk(16'h0000);
        rd_chk(CTS_OFS_SCAN_GO, 8'h00);
        $display("test untouched scan done");
        end_sim();
    end
endmodule
